// ---- design/ebhh_bus_hold.sv ----
// External bus hold handshake and program fetch width control
// Summary of operation
// - A low hold request lets any external transfer in progress finish.
// - While held, address, data, io strobe, byte enables and rw float.
// - No new transfer starts while held, until request high or disable.
// - Grant is asserted in answer to a low hold request.
// - Grant goes high when request is high or the disable bit is set.
// - With width select low, an instruction is one 32-bit fetch.
// - With width select high, two 16-bit fetches form one instruction.
// - Width select sampled at reset sets both strobe register widths.
`timescale 1ns/1ps
module ebhh_bus_hold (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic bus_hold_request_n_i,
	input wire logic hold_disable_bit_i,
	input wire logic program_width_select_i,
	input wire logic fetch_req_i,
	input wire logic [ebhh_pkg::ADDR_WIDTH-1:0] fetch_addr_i,
	input wire logic data_req_i,
	input wire logic data_write_i,
	input wire logic [ebhh_pkg::ADDR_WIDTH-1:0] data_addr_i,
	input wire logic [ebhh_pkg::DATA_WIDTH-1:0] data_wdata_i,
	input wire logic [3:0] data_byte_en_i,
	input wire logic data_io_i,
	input wire logic data_bank_i,
	input wire logic bus_ready_i,
	input wire logic [ebhh_pkg::DATA_WIDTH-1:0] ext_data_i,
	output logic [ebhh_pkg::ADDR_WIDTH-1:0] ext_addr_o,
	output logic ext_addr_oe_o,
	output logic [ebhh_pkg::DATA_WIDTH-1:0] ext_data_o,
	output logic ext_data_oe_o,
	output logic ext_ctrl_oe_o,
	output logic ext_read_write_n_o,
	output logic [3:0] bank_zero_byte_enables_n_o,
	output logic [3:0] bank_one_byte_enables_n_o,
	output logic peripheral_io_strobe_n_o,
	output logic bus_hold_grant_n_o,
	output logic fetch_done_o,
	output logic [ebhh_pkg::DATA_WIDTH-1:0] fetch_word_o,
	output logic data_done_o,
	output logic [ebhh_pkg::DATA_WIDTH-1:0] data_rdata_o,
	output logic [1:0] strobe_zero_width_o,
	output logic [1:0] strobe_one_width_o
);
	import ebhh_pkg::*;

	typedef struct packed {
		ebhh_hold_state_type hold;
		ebhh_fetch_state_type xfer;
		logic is_fetch;
		logic narrow;
		logic pending_width;
		logic [ADDR_WIDTH-1:0] addr;
		logic [DATA_WIDTH-1:0] dout;
		logic addr_oe;
		logic data_oe;
		logic ctrl_oe;
		logic rw_n;
		logic [3:0] be0_n;
		logic [3:0] be1_n;
		logic io_n;
		logic grant_n;
		logic [HALF_WIDTH-1:0] low_half;
		logic fetch_done;
		logic [DATA_WIDTH-1:0] fetch_word;
		logic data_done;
		logic [DATA_WIDTH-1:0] rdata;
		logic [1:0] w0;
		logic [1:0] w1;
	} ebhh_state_type;

	ebhh_state_type r;
	ebhh_state_type next_r;
	logic hold_req;
	logic width_high;
	logic hold_wanted;

	ebhh_pin_sync #(.RESET_LEVEL(1'b1)) u_hold_sync (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.pin_i(bus_hold_request_n_i),
		.level_o(hold_req)
	);

	// Kept out of reset so it tracks the pin while reset is held
	ebhh_pin_sync #(.RESET_LEVEL(1'b0)) u_width_sync (
		.core_clk_i(core_clk_i),
		.rst_i(1'b0),
		.pin_i(program_width_select_i),
		.level_o(width_high)
	);

	// Synchronised request is active low; disable overrides it
	assign hold_wanted = !hold_req && !hold_disable_bit_i;

	always_comb begin
		next_r = r;
		next_r.fetch_done = 1'b0;
		next_r.data_done = 1'b0;
		// Width field is loaded from the pin once, in the first cycle after reset
		if (r.pending_width) begin
			next_r.pending_width = 1'b0;
			next_r.w0 = width_high ? WIDTH_FIELD_16 : WIDTH_FIELD_32;
			next_r.w1 = width_high ? WIDTH_FIELD_16 : WIDTH_FIELD_32;
		end
		case (r.hold)
			EBHH_OWN: begin
				if (hold_wanted) begin
					next_r.hold = EBHH_DRAIN;
				end
			end
			EBHH_DRAIN: begin
				if (!hold_wanted) begin
					next_r.hold = EBHH_OWN;
				end else if (r.xfer == EBHH_IDLE) begin
					next_r.hold = EBHH_FLOAT;
					next_r.addr_oe = 1'b0;
					next_r.data_oe = 1'b0;
					next_r.ctrl_oe = 1'b0;
				end
			end
			EBHH_FLOAT: begin
				// Lines released last cycle; grant follows one cycle later
				if (!hold_wanted) begin
					next_r.hold = EBHH_OWN;
					next_r.addr_oe = 1'b1;
					next_r.ctrl_oe = 1'b1;
				end else begin
					next_r.hold = EBHH_HELD;
					next_r.grant_n = 1'b0;
				end
			end
			EBHH_HELD: begin
				if (!hold_wanted) begin
					next_r.hold = EBHH_OWN;
					next_r.grant_n = 1'b1;
					next_r.addr_oe = 1'b1;
					next_r.ctrl_oe = 1'b1;
				end
			end
			default: begin
				next_r.hold = EBHH_OWN;
			end
		endcase
		case (r.xfer)
			EBHH_IDLE: begin
				// Requests are only taken while the bus is ours
				if (r.hold == EBHH_OWN && !hold_wanted) begin
					if (fetch_req_i) begin
						next_r.xfer = EBHH_FIRST;
						next_r.is_fetch = 1'b1;
						next_r.narrow = width_high;
						next_r.addr = fetch_addr_i;
						next_r.rw_n = 1'b1;
						next_r.be0_n = 4'h0;
					end else if (data_req_i) begin
						next_r.xfer = EBHH_FIRST;
						next_r.is_fetch = 1'b0;
						next_r.narrow = 1'b0;
						next_r.addr = data_addr_i;
						next_r.rw_n = !data_write_i;
						next_r.dout = data_wdata_i;
						next_r.data_oe = data_write_i;
						if (data_io_i) begin
							next_r.io_n = 1'b0;
						end else if (data_bank_i) begin
							next_r.be1_n = ~data_byte_en_i;
						end else begin
							next_r.be0_n = ~data_byte_en_i;
						end
					end
				end
			end
			EBHH_FIRST: begin
				if (bus_ready_i) begin
					if (r.is_fetch && r.narrow) begin
						next_r.low_half = ext_data_i[HALF_WIDTH-1:0];
						next_r.addr = r.addr + 24'h000001;
						next_r.xfer = EBHH_SECOND;
					end else begin
						next_r.xfer = EBHH_IDLE;
						next_r.be0_n = 4'hF;
						next_r.be1_n = 4'hF;
						next_r.io_n = 1'b1;
						next_r.rw_n = 1'b1;
						next_r.data_oe = 1'b0;
						if (r.is_fetch) begin
							next_r.fetch_done = 1'b1;
							next_r.fetch_word = ext_data_i;
						end else begin
							next_r.data_done = 1'b1;
							next_r.rdata = ext_data_i;
						end
					end
				end
			end
			EBHH_SECOND: begin
				// Second half stays on the bus even if hold arrives now
				if (bus_ready_i) begin
					next_r.xfer = EBHH_IDLE;
					next_r.be0_n = 4'hF;
					next_r.fetch_done = 1'b1;
					next_r.fetch_word = {ext_data_i[HALF_WIDTH-1:0],
						r.low_half};
				end
			end
			default: begin
				next_r.xfer = EBHH_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			r.hold <= EBHH_OWN;
			r.xfer <= EBHH_IDLE;
			r.is_fetch <= 1'b0;
			r.narrow <= 1'b0;
			r.pending_width <= 1'b1;
			r.addr <= 24'h000000;
			r.dout <= 32'h00000000;
			r.addr_oe <= 1'b1;
			r.data_oe <= 1'b0;
			r.ctrl_oe <= 1'b1;
			r.rw_n <= 1'b1;
			r.be0_n <= 4'hF;
			r.be1_n <= 4'hF;
			r.io_n <= 1'b1;
			r.grant_n <= 1'b1;
			r.low_half <= 16'h0000;
			r.fetch_done <= 1'b0;
			r.fetch_word <= 32'h00000000;
			r.data_done <= 1'b0;
			r.rdata <= 32'h00000000;
			r.w0 <= WIDTH_FIELD_32;
			r.w1 <= WIDTH_FIELD_32;
		end else begin
			r <= next_r;
		end
	end

	assign ext_addr_o = r.addr;
	assign ext_addr_oe_o = r.addr_oe;
	assign ext_data_o = r.dout;
	assign ext_data_oe_o = r.data_oe;
	assign ext_ctrl_oe_o = r.ctrl_oe;
	assign ext_read_write_n_o = r.rw_n;
	assign bank_zero_byte_enables_n_o = r.be0_n;
	assign bank_one_byte_enables_n_o = r.be1_n;
	assign peripheral_io_strobe_n_o = r.io_n;
	assign bus_hold_grant_n_o = r.grant_n;
	assign fetch_done_o = r.fetch_done;
	assign fetch_word_o = r.fetch_word;
	assign data_done_o = r.data_done;
	assign data_rdata_o = r.rdata;
	assign strobe_zero_width_o = r.w0;
	assign strobe_one_width_o = r.w1;
endmodule : ebhh_bus_hold

// ---- design/ebhh_pin_sync.sv ----
// Three-stage synchroniser for one pin input
`timescale 1ns/1ps
module ebhh_pin_sync #(
	parameter logic RESET_LEVEL = 1'b1
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic pin_i,
	output logic level_o
);
	import ebhh_pkg::*;

	typedef struct packed {
		logic [ebhh_pkg::SYNC_STAGES-1:0] stage;
		logic level;
	} ebhh_sync_type;

	ebhh_sync_type r;
	ebhh_sync_type next_r;

	always_comb begin
		next_r = r;
		next_r.stage = {r.stage[SYNC_STAGES-2:0], pin_i};
		// Second and third stages must agree before the level moves
		if (r.stage[1] == r.stage[2]) begin
			next_r.level = r.stage[2];
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			r.stage <= {SYNC_STAGES{RESET_LEVEL}};
			r.level <= RESET_LEVEL;
		end else begin
			r <= next_r;
		end
	end

	assign level_o = r.level;
endmodule : ebhh_pin_sync

// ---- design/ebhh_pkg.sv ----
// Package of constants and types for the external bus hold handshake
package ebhh_pkg;
	localparam int ADDR_WIDTH = 24;
	localparam int DATA_WIDTH = 32;
	localparam int HALF_WIDTH = 16;
	// Reset value of the width field of both strobe bus-control registers
	localparam logic [1:0] WIDTH_FIELD_32 = 2'h3;
	localparam logic [1:0] WIDTH_FIELD_16 = 2'h2;
	// Position of the width field inside a strobe bus-control register
	localparam int WIDTH_FIELD_LSB = 0;
	// Synchroniser stages for pin inputs
	localparam int SYNC_STAGES = 3;
	typedef enum logic [1:0] {
		EBHH_IDLE,
		EBHH_FIRST,
		EBHH_SECOND
	} ebhh_fetch_state_type;
	typedef enum logic [1:0] {
		EBHH_OWN,
		EBHH_DRAIN,
		EBHH_FLOAT,
		EBHH_HELD
	} ebhh_hold_state_type;
endpackage : ebhh_pkg

// ---- tb/ebhh_bus_hold_props.sv ----
// Checker of the hold handshake at the block's ports
`timescale 1ns/1ps
module ebhh_bus_hold_props (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic bus_hold_request_n_i,
	input wire logic hold_disable_bit_i,
	input wire logic bus_ready_i,
	input wire logic ext_addr_oe_o,
	input wire logic ext_data_oe_o,
	input wire logic ext_ctrl_oe_o,
	input wire logic [3:0] bank_zero_byte_enables_n_o,
	input wire logic [3:0] bank_one_byte_enables_n_o,
	input wire logic peripheral_io_strobe_n_o,
	input wire logic bus_hold_grant_n_o,
	input wire logic fetch_done_o
);
	logic act;
	assign act = ext_ctrl_oe_o && !(&bank_zero_byte_enables_n_o
		&& &bank_one_byte_enables_n_o && peripheral_io_strobe_n_o);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	chk_held_float: assert property (!bus_hold_grant_n_o |->
		!(ext_addr_oe_o || ext_data_oe_o || ext_ctrl_oe_o)) else $error("driven");
	chk_float_first: assert property ($fell(bus_hold_grant_n_o) |->
		!$past(ext_addr_oe_o) && !$past(ext_ctrl_oe_o)) else $error("early");
	chk_held_quiet: assert property (!bus_hold_grant_n_o |->
		!fetch_done_o) else $error("fetch while held");
	chk_finish_xfer: assert property (act && !bus_ready_i |=>
		ext_ctrl_oe_o && ext_addr_oe_o) else $error("cut short");
	chk_grant_answer: assert property ((
		!bus_hold_request_n_i && !hold_disable_bit_i && (!act || bus_ready_i))[*8]
		|-> ##[0:4] (!bus_hold_grant_n_o || bus_hold_request_n_i))
		else $error("no grant");
	chk_grant_stands: assert property ((
		!bus_hold_request_n_i && !hold_disable_bit_i)[*5]
		##0 !$past(bus_hold_grant_n_o) |-> !bus_hold_grant_n_o)
		else $error("grant lost");
	chk_disable_free: assert property (hold_disable_bit_i |=>
		bus_hold_grant_n_o) else $error("grant while disabled");
	chk_req_release: assert property ($rose(bus_hold_request_n_i) &&
		!bus_hold_grant_n_o |-> ##[1:6] bus_hold_grant_n_o) else $error("stuck");
	cov_held: cover property (!bus_hold_grant_n_o);
	cov_stall: cover property (act && !bus_ready_i);
	cov_fetch: cover property (fetch_done_o);
endmodule : ebhh_bus_hold_props
bind ebhh_bus_hold ebhh_bus_hold_props props (.*);

// ---- tb/ebhh_bus_hold_test.sv ----
// Bench for the bus hold handshake block
`timescale 1ns/1ps
module ebhh_bus_hold_test;
	import ebhh_pkg::*;
	logic core_clk_i = 1'b0, rst_i = 1'b1, hold_disable_bit_i = 1'b0;
	logic program_width_select_i = 1'b0, fetch_req_i = 1'b0;
	logic data_req_i = 1'b0, data_write_i = 1'b0, data_io_i = 1'b0;
	logic data_bank_i = 1'b0, want = 1'b0, slow = 1'b0, busy, seen;
	logic bus_hold_request_n_i, bus_ready_i, ext_addr_oe_o, ext_data_oe_o;
	logic ext_ctrl_oe_o, ext_read_write_n_o, peripheral_io_strobe_n_o;
	logic bus_hold_grant_n_o, fetch_done_o, data_done_o;
	logic [1:0] strobe_zero_width_o, strobe_one_width_o;
	logic [3:0] data_byte_en_i = 4'hF, bank_zero_byte_enables_n_o;
	logic [3:0] bank_one_byte_enables_n_o;
	logic [23:0] fetch_addr_i = 24'h0, data_addr_i = 24'h0, ext_addr_o, a1;
	logic [31:0] data_wdata_i = 32'h0, ext_data_i, ext_data_o, fetch_word_o;
	logic [31:0] data_rdata_o, word, wd;
	logic [10:0] snap;
	logic [23:0] wa;
	// Row: io, data, width pin, slow, address
	logic [27:0] rows [6] = '{28'h0000100, 28'h100FFFF, 28'h4123456,
		28'hD654321, 28'h200FFFF, 28'h32ABCDE};
	int mismatches = 0, num_checks = 0;
	always #25 core_clk_i = ~core_clk_i;
	ebhh_bus_hold dut (.*);
	ebhh_far_master far (.core_clk_i, .rst_i, .want_hold_i(want),
		.slow_i(slow), .ctrl_oe_i(ext_ctrl_oe_o),
		.en0_n_i(bank_zero_byte_enables_n_o), .en1_n_i(bank_one_byte_enables_n_o),
		.io_n_i(peripheral_io_strobe_n_o), .addr_i(ext_addr_o),
		.hold_n_o(bus_hold_request_n_i), .ready_o(bus_ready_i),
		.data_o(ext_data_i), .busy_o(busy));
	task automatic check(input string what, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask : check
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : results
	task automatic wait_sig(input int k);
		for (int n = 0; n < 40; n++) begin
			@(negedge core_clk_i);
			if (k == 0 ? busy === 1'b1 : k == 1 ? (fetch_done_o | data_done_o)
				=== 1'b1 : bus_hold_grant_n_o === (k == 3)) return;
		end
		mismatches++;
		results();
	endtask : wait_sig
	task automatic do_reset(input logic p);
		logic [1:0] e;
		e = p ? WIDTH_FIELD_16 : WIDTH_FIELD_32;
		@(posedge core_clk_i);
		program_width_select_i <= p;
		rst_i <= 1'b1;
		repeat (16) @(posedge core_clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		#1;
		check("width zero", {30'h0, e}, {30'h0, strobe_zero_width_o});
		check("width one", {30'h0, e}, {30'h0, strobe_one_width_o});
		$display("reset done");
	endtask : do_reset
	task automatic xfer(input logic [27:0] r, output logic [31:0] got);
		@(posedge core_clk_i);
		fetch_addr_i <= r[23:0];
		data_addr_i <= r[23:0];
		fetch_req_i <= !r[26];
		data_req_i <= r[26];
		data_io_i <= r[27];
		data_bank_i <= r[0];
		slow <= r[24];
		wait_sig(0);
		snap = {ext_addr_oe_o, ext_read_write_n_o, ext_data_oe_o,
			bank_one_byte_enables_n_o, bank_zero_byte_enables_n_o};
		wd = ext_data_o;
		wa = ext_addr_o;
		@(posedge core_clk_i);
		fetch_req_i <= 1'b0;
		data_req_i <= 1'b0;
		wait_sig(1);
		got = r[26] ? data_rdata_o : fetch_word_o;
	endtask : xfer
	initial begin
		logic [27:0] r;
		logic [31:0] e;
		do_reset(1'b0);
		foreach (rows[i]) begin
			r = rows[i];
			if (r[25] !== program_width_select_i) do_reset(r[25]);
			xfer(r, word);
			a1 = r[23:0] + 24'h1;
			e = (r[25] && !r[26]) ? {a1[15:0], r[15:0]} : {8'h5A, r[23:0]};
			check("row word", e, word);
			$display("row %0d done", i);
		end
		@(posedge core_clk_i);
		data_write_i <= 1'b1;
		data_wdata_i <= 32'hC33C0FF0;
		data_byte_en_i <= 4'h6;
		xfer(28'h6000011, word);
		check("write lanes", {21'h0, 11'h59F}, {21'h0, snap});
		check("write data", 32'hC33C0FF0, wd);
		check("write addr", 32'h00000011, {8'h0, wa});
		@(posedge core_clk_i);
		data_write_i <= 1'b0;
		data_byte_en_i <= 4'hF;
		$display("write done");
		fork
			xfer(28'h3000040, word);
			begin
				repeat (2) @(posedge core_clk_i);
				want <= 1'b1;
			end
		join
		check("held fetch", 32'h00410040, word);
		check("grant early", 32'h1, bus_hold_grant_n_o);
		wait_sig(2);
		@(posedge core_clk_i);
		fetch_addr_i <= 24'h000080;
		fetch_req_i <= 1'b1;
		seen = 1'b0;
		repeat (10) begin
			@(negedge core_clk_i);
			seen |= busy | ext_ctrl_oe_o;
		end
		check("held quiet", 32'h0, seen);
		@(posedge core_clk_i);
		want <= 1'b0;
		xfer(28'h2000080, word);
		check("resumed", 32'h00810080, word);
		check("grant off", 32'h1, bus_hold_grant_n_o);
		$display("hold done");
		@(posedge core_clk_i);
		hold_disable_bit_i <= 1'b1;
		want <= 1'b1;
		seen = 1'b0;
		repeat (12) begin
			@(negedge core_clk_i);
			seen |= !bus_hold_grant_n_o;
		end
		check("disabled", 32'h0, seen);
		@(posedge core_clk_i);
		hold_disable_bit_i <= 1'b0;
		wait_sig(2);
		@(posedge core_clk_i);
		hold_disable_bit_i <= 1'b1;
		wait_sig(3);
		$display("disable done");
		results();
	end
endmodule : ebhh_bus_hold_test

// ---- tb/ebhh_far_master.sv ----
// Model of the outside master and the memory behind the bus
`timescale 1ns/1ps
module ebhh_far_master (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic want_hold_i,
	input wire logic slow_i,
	input wire logic ctrl_oe_i,
	input wire logic [3:0] en0_n_i,
	input wire logic [3:0] en1_n_i,
	input wire logic io_n_i,
	input wire logic [23:0] addr_i,
	output logic hold_n_o,
	output logic ready_o,
	output logic [31:0] data_o,
	output logic busy_o
);
	logic [1:0] wait_count;
	assign busy_o = ctrl_oe_i && !(&en0_n_i && &en1_n_i && io_n_i);
	// Slow memory adds two wait cycles to every access
	assign ready_o = busy_o && (!slow_i || wait_count == 2'h2);
	// Outside an access the lines show junk, not the last word
	assign data_o = busy_o ? {8'h5A, addr_i} : {8'hA5, ~addr_i};
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wait_count <= 2'h0;
			hold_n_o <= 1'b1;
		end else begin
			wait_count <= (busy_o && !ready_o) ? wait_count + 2'h1 : 2'h0;
			hold_n_o <= !want_hold_i;
		end
	end
endmodule : ebhh_far_master
